// >>> common/cfp_pkg.sv
// Shared constants for the charger flag and power-good indicator block.
package cfp_pkg;

    // Bit positions of the sticky flags in the flag vector.
    localparam int FLAG_W = 12;
    localparam int F_WARM = 0;
    localparam int F_HOT = 1;
    localparam int F_OPEN = 2;
    localparam int F_ADC = 3;
    localparam int F_COMP1 = 4;
    localparam int F_COMP2 = 5;
    localparam int F_COMP3 = 6;
    localparam int F_SAFETY = 7;
    localparam int F_MAX_CURRENT_SET_PIN = 8;
    localparam int F_WAKE1 = 9;
    localparam int F_WAKE2 = 10;
    localparam int F_RSTWARN = 11;

    // Reset value of the flag vector.
    localparam logic [FLAG_W-1:0] FLAGS_RST = 12'h000;

    // Bit positions of the inputs that arrive from outside the clock domain.
    localparam int A_W = 9;
    localparam int A_WARM = 0;
    localparam int A_HOT = 1;
    localparam int A_OPEN = 2;
    localparam int A_MAX_CURRENT_SET_PIN = 3;
    localparam int A_THERMAL_SHUTDOWN = 4;
    localparam int A_UVLO = 5;
    localparam int A_SLP = 6;
    localparam int A_OVP = 7;
    localparam int A_BUTTON = 8;

    // Settled values after reset; the pushbutton idles high.
    localparam logic [A_W-1:0] ASYNC_RST = 9'h100;

    // Power-good mode field encodings; any code with bit 1 set is GPO.
    localparam logic [1:0] POWER_GOOD_MODE_FIELD_SUPPLY = 2'h0;
    localparam logic [1:0] POWER_GOOD_MODE_FIELD_BUTTON = 2'h1;
    localparam int POWER_GOOD_MODE_FIELD_GPO_BIT = 1;

    // Clock period and interrupt pulse length.
    localparam int unsigned CLK_PERIOD_NS = 32'h0000_0064;
    localparam int unsigned INT_PULSE_NS = 32'h0001_F400;
    localparam int unsigned INT_PULSE_CYCLES = INT_PULSE_NS / CLK_PERIOD_NS;

    // Pushbutton hold times in milliseconds (plain defaults).
    localparam int unsigned WAKE1_MS = 32'h0000_01F4;
    localparam int unsigned WAKE2_MS = 32'h0000_07D0;
    localparam int unsigned RSTWARN_MS = 32'h0000_0BB8;
    localparam int unsigned CYC_PER_MS = 32'h000F_4240 / CLK_PERIOD_NS;
    localparam int unsigned WAKE1_CYCLES = WAKE1_MS * CYC_PER_MS;
    localparam int unsigned WAKE2_CYCLES = WAKE2_MS * CYC_PER_MS;
    localparam int unsigned RSTWARN_CYCLES = RSTWARN_MS * CYC_PER_MS;

    // Width of the pulse and hold counters.
    localparam int CNT_W = 32;

endpackage

// >>> core/cfp_sync.sv
// Three-stage input synchroniser that settles once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none
module cfp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock, reset and enable.
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // Raw and settled levels.
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] level_o
);

    logic [WIDTH-1:0] s1; // First stage, read only by the second.
    logic [WIDTH-1:0] s2; // Second stage.
    logic [WIDTH-1:0] s3; // Third stage.
    logic [WIDTH-1:0] next_level; // Settled value for the next edge.

    // A bit moves on only when two stages agree, which drops single glitches.
    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            next_level[i] = (s2[i] == s3[i]) ? s3[i] : level_o[i];
        end
    end

    // The chain and the settled value freeze while the enable is low.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s1 <= RESET_VAL;
            s2 <= RESET_VAL;
            s3 <= RESET_VAL;
            level_o <= RESET_VAL;
        end
        else if (ce_i)
        begin
            s1 <= async_i;
            s2 <= s1;
            s3 <= s2;
            level_o <= next_level;
        end
    end

endmodule
`default_nettype wire

// >>> core/cfp_flags.sv
// Charger fault flags, interrupt pulse, charge gating and power-good pin.
// Summary of operation
// - Warm: set flag, lower regulation voltage.
// - Hot: set flag, pause charging and timer.
// - Conversion done sets ready flag, nothing else.
// - Open thermistor: set flag, pause charge, timer.
// - Timer expiry latches fault until supply/enable toggles.
// - Current-pin open disables charging until reset.
// - Button held low sets wake flags.
// - Long button hold sets reset-warning flag only.
// - Default mode: pin low while supply valid.
// - Mode 01: pin follows pushbutton input.
// - Mode 1x: pin follows host level bit.
// - Thermistor fault gives 128 us interrupt pulse.
// - Flags stay set until host read clears; the expiry flag waits for a supply/enable toggle instead.
`timescale 1ns/10ps
`default_nettype none
module cfp_flags #(
    parameter logic [31:0] WAKE1_CYCLES = cfp_pkg::WAKE1_CYCLES,
    parameter logic [31:0] WAKE2_CYCLES = cfp_pkg::WAKE2_CYCLES,
    parameter logic [31:0] RSTWARN_CYCLES = cfp_pkg::RSTWARN_CYCLES
) (
    // Clock, reset and enable.
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // Analog status levels, asynchronous to the clock.
    input wire logic thermistor_warm_i,
    input wire logic thermistor_hot_i,
    input wire logic thermistor_open_i,
    input wire logic max_current_set_pin_open_i,
    input wire logic thermal_shutdown_i,
    input wire logic input_supply_above_uvlo_i,
    input wire logic input_supply_above_bat_slp_i,
    input wire logic input_supply_below_ovp_i,
    input wire logic pushbutton_input_n_i,
    // Events from logic on the same clock.
    input wire logic adc_done_i,
    input wire logic [2:0] comparator_match_i,
    input wire logic safety_timer_expired_i,
    // Host control.
    input wire logic charge_enable_i,
    input wire logic flag_read_i,
    input wire logic [1:0] power_good_mode_field_i,
    input wire logic general_output_level_bit_i,
    // Flags and interrupt.
    output logic [cfp_pkg::FLAG_W-1:0] flags_o,
    output logic interrupt_pulse_o,
    // Charger and power path control.
    output logic charge_allow_o,
    output logic vbat_reduced_o,
    output logic safety_timer_run_o,
    output logic safety_timer_reset_o,
    output logic load_switch_allow_o,
    output logic power_path_allow_o,
    // Open-drain power-good pin.
    output logic power_good_output_o,
    output logic power_good_output_oe_o
);

    // Returns one when a hold counter reaches the given threshold.
    function automatic logic hold_reached(input logic [31:0] cnt,
                                          input logic [31:0] thr);
        hold_reached = (cnt == thr);
    endfunction

    logic [cfp_pkg::A_W-1:0] st; // Settled asynchronous levels.
    logic [cfp_pkg::A_W-1:0] st_prev; // Levels one edge earlier.
    logic [cfp_pkg::A_W-1:0] next_st_prev;
    logic [cfp_pkg::FLAG_W-1:0] next_flags;
    logic [cfp_pkg::FLAG_W-1:0] set_evt; // Hardware events this edge.
    logic [cfp_pkg::FLAG_W-1:0] clr_mask; // Bits a read or toggle clears.
    logic [cfp_pkg::CNT_W-1:0] int_cnt; // Cycles left in the pulse.
    logic [cfp_pkg::CNT_W-1:0] next_int_cnt;
    logic next_int;
    logic [31:0] hold_cnt; // Cycles the button has been low.
    logic [31:0] next_hold_cnt;
    logic safety_latch; // Expiry fault holding charge off.
    logic next_safety_latch;
    logic max_current_set_pin_latch; // Open current pin, held until reset.
    logic next_max_current_set_pin_latch;
    logic vin_valid_prev; // Supply valid one edge earlier.
    logic next_vin_valid_prev;
    logic ce_prev; // Host charge enable one edge earlier.
    logic next_ce_prev;
    logic toggle; // Supply or charge enable fell.
    logic vin_valid; // Supply inside its window.
    logic tfault; // A thermistor condition just appeared.
    logic next_charge, next_vbat_red, next_run, next_treset;
    logic next_ls, next_pp, next_pg_oe;

    // Synchronise all asynchronous status levels.
    cfp_sync #(
        .WIDTH(cfp_pkg::A_W),
        .RESET_VAL(cfp_pkg::ASYNC_RST)
    ) u_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .async_i({pushbutton_input_n_i, input_supply_below_ovp_i,
                  input_supply_above_bat_slp_i, input_supply_above_uvlo_i,
                  thermal_shutdown_i, max_current_set_pin_open_i,
                  thermistor_open_i, thermistor_hot_i, thermistor_warm_i}),
        .level_o(st)
    );

    assign vin_valid = st[cfp_pkg::A_UVLO] & st[cfp_pkg::A_SLP]
                       & st[cfp_pkg::A_OVP];
    assign toggle = (vin_valid_prev & ~vin_valid)
                    | (ce_prev & ~charge_enable_i);

    // Set events for each flag, rising edges for status levels; a set beats a clear on the same edge.
    always_comb
    begin
        next_st_prev = st;
        next_vin_valid_prev = vin_valid;
        next_ce_prev = charge_enable_i;
        set_evt = '0;
        set_evt[cfp_pkg::F_WARM] = st[cfp_pkg::A_WARM]
                                   & ~st_prev[cfp_pkg::A_WARM];
        set_evt[cfp_pkg::F_HOT] = st[cfp_pkg::A_HOT]
                                  & ~st_prev[cfp_pkg::A_HOT];
        set_evt[cfp_pkg::F_OPEN] = st[cfp_pkg::A_OPEN]
                                   & ~st_prev[cfp_pkg::A_OPEN];
        set_evt[cfp_pkg::F_ADC] = adc_done_i;
        set_evt[cfp_pkg::F_COMP1] = comparator_match_i[0];
        set_evt[cfp_pkg::F_COMP2] = comparator_match_i[1];
        set_evt[cfp_pkg::F_COMP3] = comparator_match_i[2];
        set_evt[cfp_pkg::F_SAFETY] = safety_timer_expired_i;
        set_evt[cfp_pkg::F_MAX_CURRENT_SET_PIN] = st[cfp_pkg::A_MAX_CURRENT_SET_PIN]
                                   & ~st_prev[cfp_pkg::A_MAX_CURRENT_SET_PIN];
        set_evt[cfp_pkg::F_WAKE1] = hold_reached(next_hold_cnt,
                                                 WAKE1_CYCLES);
        set_evt[cfp_pkg::F_WAKE2] = hold_reached(next_hold_cnt,
                                                 WAKE2_CYCLES);
        set_evt[cfp_pkg::F_RSTWARN] = hold_reached(next_hold_cnt,
                                                   RSTWARN_CYCLES);
        // A read clears every flag except the expiry fault, which waits
        // for a supply or enable toggle instead.
        clr_mask = flag_read_i ? '1 : '0;
        clr_mask[cfp_pkg::F_SAFETY] = toggle;
        next_flags = (flags_o & ~clr_mask) | set_evt;
    end

    // Button hold counter runs while the button is low, saturating at top.
    always_comb
    begin
        if (st[cfp_pkg::A_BUTTON])
        begin
            next_hold_cnt = '0;
        end
        else if (hold_cnt != 32'hFFFF_FFFF)
        begin
            next_hold_cnt = hold_cnt + 32'h0000_0001;
        end
        else
        begin
            next_hold_cnt = hold_cnt;
        end
    end

    // Interrupt pulse of fixed length on each new thermistor condition.
    always_comb
    begin
        tfault = set_evt[cfp_pkg::F_WARM] | set_evt[cfp_pkg::F_HOT]
                 | set_evt[cfp_pkg::F_OPEN];
        if (tfault)
        begin
            next_int_cnt = cfp_pkg::CNT_W'(cfp_pkg::INT_PULSE_CYCLES);
        end
        else if (int_cnt != '0)
        begin
            next_int_cnt = int_cnt - cfp_pkg::CNT_W'(1);
        end
        else
        begin
            next_int_cnt = '0;
        end
        next_int = (next_int_cnt != '0);
    end

    // Charger gating, fault latches and the power-good pin drive.
    always_comb
    begin
        next_safety_latch = (safety_latch & ~toggle)
                            | safety_timer_expired_i;
        next_max_current_set_pin_latch = max_current_set_pin_latch | st[cfp_pkg::A_MAX_CURRENT_SET_PIN];
        next_treset = safety_latch & toggle;
        next_charge = charge_enable_i & ~st[cfp_pkg::A_HOT]
                      & ~st[cfp_pkg::A_OPEN]
                      & ~next_safety_latch
                      & ~next_max_current_set_pin_latch
                      & ~st[cfp_pkg::A_THERMAL_SHUTDOWN];
        next_vbat_red = st[cfp_pkg::A_WARM];
        next_run = ~st[cfp_pkg::A_HOT] & ~st[cfp_pkg::A_OPEN]
                   & ~st[cfp_pkg::A_THERMAL_SHUTDOWN];
        next_ls = ~st[cfp_pkg::A_THERMAL_SHUTDOWN];
        next_pp = ~st[cfp_pkg::A_THERMAL_SHUTDOWN];
        if (power_good_mode_field_i[cfp_pkg::POWER_GOOD_MODE_FIELD_GPO_BIT])
        begin
            next_pg_oe = ~general_output_level_bit_i;
        end
        else if (power_good_mode_field_i == cfp_pkg::POWER_GOOD_MODE_FIELD_BUTTON)
        begin
            next_pg_oe = ~st[cfp_pkg::A_BUTTON];
        end
        else
        begin
            next_pg_oe = vin_valid;
        end
    end

    // Register every piece of state; nothing moves while the enable is low.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st_prev <= cfp_pkg::ASYNC_RST;
            vin_valid_prev <= 1'b0;
            ce_prev <= 1'b0;
            flags_o <= cfp_pkg::FLAGS_RST;
            hold_cnt <= '0;
            int_cnt <= '0;
            interrupt_pulse_o <= 1'b0;
            safety_latch <= 1'b0;
            max_current_set_pin_latch <= 1'b0;
            safety_timer_reset_o <= 1'b0;
            charge_allow_o <= 1'b0;
            vbat_reduced_o <= 1'b0;
            safety_timer_run_o <= 1'b0;
            load_switch_allow_o <= 1'b0;
            power_path_allow_o <= 1'b0;
            power_good_output_o <= 1'b0;
            power_good_output_oe_o <= 1'b0;
        end
        else if (ce_i)
        begin
            st_prev <= next_st_prev;
            vin_valid_prev <= next_vin_valid_prev;
            ce_prev <= next_ce_prev;
            flags_o <= next_flags;
            hold_cnt <= next_hold_cnt;
            int_cnt <= next_int_cnt;
            interrupt_pulse_o <= next_int;
            safety_latch <= next_safety_latch;
            max_current_set_pin_latch <= next_max_current_set_pin_latch;
            safety_timer_reset_o <= next_treset;
            charge_allow_o <= next_charge;
            vbat_reduced_o <= next_vbat_red;
            safety_timer_run_o <= next_run;
            load_switch_allow_o <= next_ls;
            power_path_allow_o <= next_pp;
            power_good_output_o <= 1'b0;
            power_good_output_oe_o <= next_pg_oe;
        end
    end

    // Checks on the flag, gating and pin behaviour.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_warm_rise;
        ce_i && st[cfp_pkg::A_WARM] && !st_prev[cfp_pkg::A_WARM];
    endsequence

    sequence s_pulse_start;
        ce_i && tfault;
    endsequence

    chk_warm_flag: assert property (
        s_warm_rise |=> flags_o[cfp_pkg::F_WARM] && vbat_reduced_o)
        else $error("warm edge did not set flag and lower voltage");

    chk_hot_pause: assert property (
        ce_i && st[cfp_pkg::A_HOT] |=> !charge_allow_o && !safety_timer_run_o)
        else $error("hot condition did not pause charge and timer");

    chk_adc_flag: assert property (
        ce_i && adc_done_i |=> flags_o[cfp_pkg::F_ADC])
        else $error("conversion done did not set ready flag");

    chk_open_pause: assert property (
        ce_i && st[cfp_pkg::A_OPEN] |=> !charge_allow_o && !safety_timer_run_o)
        else $error("open thermistor did not pause charge and timer");

    chk_expiry_hold: assert property (
        ce_i && safety_timer_expired_i ##1 (ce_i && !toggle && !flag_read_i)
        |=> flags_o[cfp_pkg::F_SAFETY] && !charge_allow_o)
        else $error("expiry fault did not hold charge off");

    chk_max_current_set_pin_latch: assert property (
        max_current_set_pin_latch |=> max_current_set_pin_latch && !charge_allow_o)
        else $error("current pin fault released before reset");

    chk_wake_one: assert property (
        ce_i && hold_reached(next_hold_cnt, WAKE1_CYCLES)
        |=> flags_o[cfp_pkg::F_WAKE1])
        else $error("wake one flag not set at hold time");

    chk_reset_warn: assert property (
        ce_i && hold_reached(next_hold_cnt, RSTWARN_CYCLES)
        |=> flags_o[cfp_pkg::F_RSTWARN])
        else $error("reset warning flag not set at hold time");

    chk_pg_button: assert property (
        ce_i && power_good_mode_field_i == cfp_pkg::POWER_GOOD_MODE_FIELD_BUTTON
        |=> power_good_output_oe_o == !$past(st[cfp_pkg::A_BUTTON]))
        else $error("power-good pin does not follow pushbutton");

    chk_pg_gpo: assert property (
        ce_i && power_good_mode_field_i[cfp_pkg::POWER_GOOD_MODE_FIELD_GPO_BIT]
        |=> power_good_output_oe_o == !$past(general_output_level_bit_i))
        else $error("power-good pin does not follow level bit");

    chk_int_pulse: assert property (
        s_pulse_start |=> interrupt_pulse_o [*8])
        else $error("interrupt pulse ended too early");

    chk_read_clear: assert property (
        ce_i && flag_read_i && set_evt == '0 && !toggle
        |=> flags_o == ($past(flags_o) & (12'h001 << cfp_pkg::F_SAFETY)))
        else $error("host read did not clear flags");

    chk_thermal_shutdown_off: assert property (
        ce_i && st[cfp_pkg::A_THERMAL_SHUTDOWN]
        |=> !charge_allow_o && !load_switch_allow_o && !power_path_allow_o)
        else $error("thermal shutdown did not disable outputs");

endmodule
`default_nettype wire

// >>> tb/cfp_host_model.sv
// Host processor model that reads and clears the charger flags.
`timescale 1ns/10ps
`default_nettype none
module cfp_host_model (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rstn_i,
    // Bench request and the flag vector that the host sees.
    input wire logic read_req_i,
    input wire logic [cfp_pkg::FLAG_W-1:0] flags_i,
    // Read strobe to the block and the value that the host read.
    output logic flag_read_o,
    output logic [cfp_pkg::FLAG_W-1:0] read_data_o
);
    // The strobe changes just after a rising edge and stands one cycle.
    // The value read is taken at the same edge that takes the strobe.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            flag_read_o <= 1'h0;
            read_data_o <= '0;
        end
        else
        begin
            flag_read_o <= read_req_i;
            if (flag_read_o)
            begin
                read_data_o <= flags_i;
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/test_charger_flags_and_pg_output.sv
// Self-checking bench for the charger flag and power-good block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) \
    begin \
        n_compared++; \
        if ((g) !== (e)) \
        begin \
            fails++; \
            $display("Error t=%0t got %h exp %h", $time, (g), (e)); \
        end \
    end
module test_charger_flags_and_pg_output;
    // Shortened hold counts so that the button hold runs stay brief.
    localparam int W1 = 20;
    localparam int W2 = 40;
    localparam int W3 = 60;
    // Clock, reset and stimulus driven by the bench.
    logic clk_i = 1'h0;
    logic rstn_i = 1'h0;
    logic warm = 1'h0, hot = 1'h0, opn = 1'h0, max_current_set_pin = 1'h0, thermal_shutdown = 1'h0;
    logic [2:0] sup = 3'h7;
    logic btn_n = 1'h1, adc = 1'h0, expd = 1'h0, cen = 1'h1, gpo = 1'h1;
    logic [2:0] cmp = 3'h0;
    logic [1:0] mode = 2'h0;
    logic clk_en = 1'h1; // Clock enable of the block; low freezes it.
    logic read_req = 1'h0;
    // Outputs observed from the block and the host model.
    logic flag_read, intr, allow, vred, trun, treset, ls, pp, pgo, pgoe;
    logic [cfp_pkg::FLAG_W-1:0] flags, rdata, snap;
    logic [3:0] ev_exp;
    logic [31:0] v;
    int fails = 0;
    int n_compared = 0;
    int k;

    // Free-running 10 MHz clock.
    initial
    begin
        forever #50 clk_i = ~clk_i;
    end

    // Block under test with short button hold counts.
    cfp_flags #(.WAKE1_CYCLES(W1), .WAKE2_CYCLES(W2), .RSTWARN_CYCLES(W3))
    i_cfp_flags (
        .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(clk_en),
        .thermistor_warm_i(warm), .thermistor_hot_i(hot),
        .thermistor_open_i(opn), .max_current_set_pin_open_i(max_current_set_pin),
        .thermal_shutdown_i(thermal_shutdown), .input_supply_above_uvlo_i(sup[0]),
        .input_supply_above_bat_slp_i(sup[1]),
        .input_supply_below_ovp_i(sup[2]), .pushbutton_input_n_i(btn_n),
        .adc_done_i(adc), .comparator_match_i(cmp),
        .safety_timer_expired_i(expd), .charge_enable_i(cen),
        .flag_read_i(flag_read), .power_good_mode_field_i(mode),
        .general_output_level_bit_i(gpo), .flags_o(flags),
        .interrupt_pulse_o(intr), .charge_allow_o(allow),
        .vbat_reduced_o(vred), .safety_timer_run_o(trun),
        .safety_timer_reset_o(treset), .load_switch_allow_o(ls),
        .power_path_allow_o(pp), .power_good_output_o(pgo),
        .power_good_output_oe_o(pgoe)
    );

    // Host that reads and clears the flags.
    cfp_host_model i_cfp_host_model (
        .clk_i(clk_i), .rstn_i(rstn_i), .read_req_i(read_req),
        .flags_i(flags), .flag_read_o(flag_read), .read_data_o(rdata)
    );

    // Expected pin enable: host bit, then button, then supply window.
    function automatic logic exp_oe(logic [1:0] m, logic [2:0] s,
                                    logic b_n, logic g);
        if (m[cfp_pkg::POWER_GOOD_MODE_FIELD_GPO_BIT])
            return !g;
        if (m == cfp_pkg::POWER_GOOD_MODE_FIELD_BUTTON)
            return !b_n;
        return &s;
    endfunction

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Steps n falling edges, where all stimulus changes.
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // Waits for a flag bit under a bound; running out is a mismatch.
    task automatic wait_flag(input int b, input int lim);
        int i;
        for (i = 0; i < lim && flags[b] !== 1'h1; i++)
            tick(1);
        if (flags[b] !== 1'h1)
        begin
            fails++;
            results();
        end
    endtask

    // Host read: one-cycle request, then time for the clear to land.
    task automatic host_read();
        read_req = 1'h1;
        tick(1);
        read_req = 1'h0;
        tick(3);
    endtask

    // Waits for the interrupt pulse and measures its length in cycles.
    task automatic check_pulse();
        k = 0;
        for (int i = 0; i < 10 && intr !== 1'h1; i++)
            tick(1);
        while (intr === 1'h1 && k < 2000)
        begin
            k++;
            tick(1);
        end
        `CHK(k, int'(cfp_pkg::INT_PULSE_CYCLES));
    endtask

    // Main sequence of scenarios.
    initial
    begin
        void'($urandom(64));
        tick(12);
        rstn_i = 1'h1;
        tick(7);
        `CHK(flags, cfp_pkg::FLAGS_RST);
        `CHK(pgoe, 1'h1);
        // Warm band: flag, lowered voltage, charging and timer untouched.
        warm = 1'h1;
        check_pulse();
        `CHK(flags[cfp_pkg::F_WARM], 1'h1);
        `CHK({vred, allow, trun}, 3'h7);
        warm = 1'h0;
        tick(6);
        `CHK(vred, 1'h0);
        // Hot, then open: flag, pulse, charging and timer paused.
        for (int s = 0; s < 2; s++)
        begin
            hot = (s == 0);
            opn = (s == 1);
            check_pulse();
            `CHK(flags[s + 1], 1'h1);
            `CHK({allow, trun}, 2'h0);
            hot = 1'h0;
            opn = 1'h0;
            tick(6);
            `CHK({allow, trun}, 2'h3);
        end
        host_read();
        `CHK(rdata[2:0], 3'h7);
        `CHK(flags, 12'h000);
        // Random conversion and comparator events accumulate flags.
        ev_exp = 4'h0;
        repeat (20)
        begin
            v = $urandom;
            adc = v[0];
            cmp = v[3:1];
            ev_exp = ev_exp | v[3:0];
            tick(1);
            adc = 1'h0;
            cmp = 3'h0;
            tick(1);
            `CHK(flags[6:3], ev_exp);
            `CHK({allow, trun, ls, pp}, 4'hf);
        end
        // A conversion on the very edge of a read keeps its flag.
        read_req = 1'h1;
        tick(1);
        read_req = 1'h0;
        adc = 1'h1;
        tick(1);
        adc = 1'h0;
        tick(2);
        `CHK(flags, 12'h008);
        // Safety timer expiry survives a read and clears on enable fall.
        expd = 1'h1;
        tick(1);
        expd = 1'h0;
        tick(2);
        `CHK({flags[cfp_pkg::F_SAFETY], allow}, 2'h2);
        host_read();
        `CHK({flags[cfp_pkg::F_SAFETY], allow}, 2'h2);
        cen = 1'h0;
        k = 0;
        for (int i = 0; i < 5; i++)
        begin
            tick(1);
            k += (treset === 1'h1);
        end
        `CHK(k, 1);
        `CHK(flags[cfp_pkg::F_SAFETY], 1'h0);
        cen = 1'h1;
        tick(2);
        `CHK(allow, 1'h1);
        // Power-good pin in every mode code with random levels.
        for (int i = 0; i < 24; i++)
        begin
            v = $urandom;
            mode = 2'(i);
            sup = v[4:2];
            btn_n = v[5];
            gpo = v[6];
            tick(7);
            `CHK(pgoe, exp_oe(mode, sup, btn_n, gpo));
            `CHK(pgo, 1'h0);
        end
        sup = 3'h7;
        btn_n = 1'h1;
        tick(7);
        host_read();
        // Long button hold walks through the three hold flags in order.
        mode = cfp_pkg::POWER_GOOD_MODE_FIELD_BUTTON;
        btn_n = 1'h0;
        tick(W1 - 5);
        `CHK(flags[cfp_pkg::F_WAKE1], 1'h0);
        wait_flag(cfp_pkg::F_WAKE1, 20);
        `CHK(flags[cfp_pkg::F_WAKE2], 1'h0);
        wait_flag(cfp_pkg::F_WAKE2, W2 - W1 + 10);
        `CHK(flags[cfp_pkg::F_RSTWARN], 1'h0);
        wait_flag(cfp_pkg::F_RSTWARN, W3 - W2 + 10);
        `CHK({allow, ls, pp, pgoe}, 4'hf);
        btn_n = 1'h1;
        mode = cfp_pkg::POWER_GOOD_MODE_FIELD_SUPPLY;
        tick(7);
        // Thermal shutdown cuts every path and raises no flag.
        snap = flags;
        // With the enable low, events and status changes leave no trace.
        clk_en = 1'h0;
        adc = 1'h1;
        warm = 1'h1;
        tick(7);
        `CHK({flags, intr}, {snap, 1'h0});
        adc = 1'h0;
        warm = 1'h0;
        clk_en = 1'h1;
        tick(1);
        // A warm level that stands for one cycle only is filtered out.
        warm = 1'h1;
        tick(1);
        warm = 1'h0;
        tick(7);
        `CHK({flags, intr}, {snap, 1'h0});
        thermal_shutdown = 1'h1;
        tick(7);
        `CHK({allow, trun, ls, pp, intr}, 5'h00);
        `CHK(flags, snap);
        thermal_shutdown = 1'h0;
        tick(7);
        `CHK({allow, ls, pp}, 3'h7);
        // Open current pin: charging stays off until the next reset.
        max_current_set_pin = 1'h1;
        tick(7);
        `CHK({flags[cfp_pkg::F_MAX_CURRENT_SET_PIN], allow}, 2'h2);
        max_current_set_pin = 1'h0;
        tick(7);
        host_read();
        `CHK({flags[cfp_pkg::F_MAX_CURRENT_SET_PIN], allow}, 2'h0);
        rstn_i = 1'h0;
        tick(2);
        rstn_i = 1'h1;
        tick(7);
        `CHK(allow, 1'h1);
        results();
    end
endmodule
`default_nettype wire
